// ===== hw/tmr_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
`define TMR_ADDR_TEMP_CTRL    7'h4e
`define TMR_ADDR_TEMP_RESULT  7'h4f
`define TMR_ADDR_LNA          7'h58
`define TMR_ADDR_PA_A         7'h5a
`define TMR_ADDR_PA_B         7'h5c
`define TMR_ADDR_DAGC         7'h6f
`define TMR_ADDR_AFC          7'h71
`define TMR_BIT_TRIGGER       3
`define TMR_BIT_ACTIVE        2
`define TMR_CTRL_FIXED        8'h01
`define TMR_RST_LNA           8'h1b
`define TMR_LNA_HIGH          8'h2d
`define TMR_RST_PA_A          8'h55
`define TMR_PA_A_BOOST        8'h5d
`define TMR_RST_PA_B          8'h70
`define TMR_PA_B_BOOST        8'h7c
`define TMR_RST_DAGC          8'h30
`define TMR_DAGC_NORMAL       8'h00
`define TMR_DAGC_LOWBETA      8'h20
`define TMR_RST_AFC           8'h00
`define TMR_AFC_STEP_HZ       488
`define TMR_CLK_HZ            40000000
`define TMR_CONV_CYCLES       64
`define TMR_POR_CYCLES        16
`endif

// ===== hw/tmr_pkg.sv
// types for the temperature and test register block
package tmr_pkg;
   typedef enum logic [1:0] {TMR_IDLE, TMR_CONV, TMR_DONE} tmr_state_type;
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } tmr_req_type;
   typedef struct packed
   {
      logic [7:0] lna;
      logic [7:0] pa_a;
      logic [7:0] pa_b;
      logic [7:0] dagc;
      logic [7:0] afc;
   } tmr_tune_type;
endpackage

// ===== hw/tmr_reset_seq.sv
// reset sequencer: power-on and pin reset stretched into one internal reset
`timescale 1ns/1ps
`default_nettype none
`include "tmr_regs.svh"
module tmr_reset_seq
#(
   parameter int HOLD_CYCLES = `TMR_POR_CYCLES
)
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic reset_pin,
   output var  logic core_reset
);
   logic [2:0]  sync_q;
   logic [2:0]  sync_d;
   logic        pin_q;
   logic        pin_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic        hold_q;
   logic        hold_d;

   always_comb
   begin
      sync_d = {sync_q[1:0], reset_pin};
      pin_d  = (sync_q[2] == sync_q[1]) ? sync_q[2] : pin_q;
      cnt_d  = cnt_q;
      hold_d = hold_q;
      if (pin_d)
      begin
         cnt_d  = 16'h0000;
         hold_d = 1'b1;
      end
      else if (hold_q)
      begin
         if (cnt_q == 16'(HOLD_CYCLES - 1))
            hold_d = 1'b0;
         else
            cnt_d = cnt_q + 16'h0001;
      end
   end

   // power-on reset arrives as reset; no host action needed
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sync_q <= 3'h0;
         pin_q  <= 1'b0;
         cnt_q  <= 16'h0000;
         hold_q <= 1'b1;
      end
      else
      begin
         sync_q <= sync_d;
         pin_q  <= pin_d;
         cnt_q  <= cnt_d;
         hold_q <= hold_d;
      end
   end

   assign core_reset = hold_q;
endmodule
`default_nettype wire

// ===== hw/tmr_top.sv
// temperature measurement, test tuning registers and reset sequencing
`timescale 1ns/1ps
`default_nettype none
`include "tmr_regs.svh"
module tmr_top
#(
   parameter int CONV_CYCLES = `TMR_CONV_CYCLES,
   parameter int HOLD_CYCLES = `TMR_POR_CYCLES
)
(
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire logic               reset_pin,
   input  wire tmr_pkg::tmr_req_type req,
   input  wire logic [7:0]         sensor_code,
   input  wire logic               low_index_afc_enable,
   output logic [7:0]              rdata,
   output logic                    temp_conv_active,
   output logic                    rx_inhibit,
   output logic                    ready,
   output logic                    afc_apply,
   output logic [15:0]             afc_offset_steps,
   output tmr_pkg::tmr_tune_type   tune
);
   logic                  core_reset;
   tmr_pkg::tmr_state_type st_q;
   tmr_pkg::tmr_state_type st_d;
   logic [15:0]           cnt_q;
   logic [15:0]           cnt_d;
   logic [7:0]            result_q;
   logic [7:0]            result_d;
   tmr_pkg::tmr_tune_type tune_q;
   tmr_pkg::tmr_tune_type tune_d;
   logic [7:0]            rdata_q;
   logic [7:0]            rdata_d;
   logic                  ready_q;
   logic                  afc_en_q;
   logic                  active_q;
   logic                  active_d;
   logic [15:0]           steps_q;
   logic [15:0]           steps_d;

   tmr_reset_seq #(.HOLD_CYCLES(HOLD_CYCLES)) u_rst
   (
      .clk        (clk),
      .reset      (reset),
      .reset_pin  (reset_pin),
      .core_reset (core_reset)
   );

   function automatic logic hit(input tmr_pkg::tmr_req_type r, input logic [6:0] a);
      hit = r.wr && (r.addr == a);
   endfunction

   // measurement sequencer
   always_comb
   begin
      st_d     = st_q;
      cnt_d    = cnt_q;
      result_d = result_q;
      case (st_q)
         tmr_pkg::TMR_IDLE:
         begin
            if (hit(req, `TMR_ADDR_TEMP_CTRL) && req.wdata[`TMR_BIT_TRIGGER])
            begin
               st_d  = tmr_pkg::TMR_CONV;
               cnt_d = 16'h0000;
            end
         end
         tmr_pkg::TMR_CONV:
         begin
            // retrigger during conversion is ignored
            if (cnt_q == 16'(CONV_CYCLES - 1))
               st_d = tmr_pkg::TMR_DONE;
            else
               cnt_d = cnt_q + 16'h0001;
         end
         tmr_pkg::TMR_DONE:
         begin
            // sensor code already counts down with rising temperature
            result_d = sensor_code;
            st_d     = tmr_pkg::TMR_IDLE;
         end
         default:
            st_d = tmr_pkg::TMR_IDLE;
      endcase
   end

   // tuning registers
   always_comb
   begin
      tune_d = tune_q;
      if (hit(req, `TMR_ADDR_LNA))
         tune_d.lna = req.wdata;
      if (hit(req, `TMR_ADDR_PA_A))
         tune_d.pa_a = req.wdata;
      if (hit(req, `TMR_ADDR_PA_B))
         tune_d.pa_b = req.wdata;
      if (hit(req, `TMR_ADDR_DAGC))
         tune_d.dagc = req.wdata;
      if (hit(req, `TMR_ADDR_AFC))
         tune_d.afc = req.wdata;
   end

   // read mux; unmapped addresses read zero
   always_comb
   begin
      rdata_d = rdata_q;
      if (req.rd)
      begin
         case (req.addr)
            `TMR_ADDR_TEMP_CTRL:
               rdata_d = `TMR_CTRL_FIXED | {5'h00, (st_q != tmr_pkg::TMR_IDLE), 2'h0};
            `TMR_ADDR_TEMP_RESULT:
               rdata_d = result_q;
            `TMR_ADDR_LNA:
               rdata_d = tune_q.lna;
            `TMR_ADDR_PA_A:
               rdata_d = tune_q.pa_a;
            `TMR_ADDR_PA_B:
               rdata_d = tune_q.pa_b;
            `TMR_ADDR_DAGC:
               rdata_d = tune_q.dagc;
            `TMR_ADDR_AFC:
               rdata_d = tune_q.afc;
            default:
               rdata_d = 8'h00;
         endcase
      end
   end

   // status and offset taken from next values so they switch with the state, glitch free
   always_comb
   begin
      active_d = (st_d != tmr_pkg::TMR_IDLE);
      steps_d  = low_index_afc_enable ? {8'h00, tune_d.afc} : 16'h0000;
   end

   always_ff @(posedge clk)
   begin
      if (reset || core_reset)
      begin
         st_q     <= tmr_pkg::TMR_IDLE;
         cnt_q    <= 16'h0000;
         result_q <= 8'h00;
         tune_q   <= {`TMR_RST_LNA, `TMR_RST_PA_A, `TMR_RST_PA_B, `TMR_RST_DAGC, `TMR_RST_AFC};
         rdata_q  <= 8'h00;
         ready_q  <= 1'b0;
         afc_en_q <= 1'b0;
         active_q <= 1'b0;
         steps_q  <= 16'h0000;
      end
      else
      begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         result_q <= result_d;
         tune_q   <= tune_d;
         rdata_q  <= rdata_d;
         ready_q  <= 1'b1;
         afc_en_q <= low_index_afc_enable;
         active_q <= active_d;
         steps_q  <= steps_d;
      end
   end

   assign rdata            = rdata_q;
   assign temp_conv_active = active_q;
   assign rx_inhibit       = active_q;
   assign ready            = ready_q;
   assign tune             = tune_q;
   assign afc_apply        = afc_en_q;
   // offset in units of the 488 hz step; zero while disabled
   assign afc_offset_steps = steps_q;

   property p_conv_len;
      @(posedge clk) disable iff (reset || core_reset)
      $rose(temp_conv_active) |-> temp_conv_active [*8];
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion too short");

   property p_trigger;
      @(posedge clk) disable iff (reset || core_reset)
      (st_q == tmr_pkg::TMR_IDLE && hit(req, `TMR_ADDR_TEMP_CTRL) && req.wdata[3])
         |=> temp_conv_active;
   endproperty
   a_trigger: assert property (p_trigger) else $error("trigger not taken");

   property p_trig_reads_zero;
      @(posedge clk) disable iff (reset || core_reset)
      $past(req.rd) && $past(req.addr) == `TMR_ADDR_TEMP_CTRL |-> rdata[3] == 1'b0;
   endproperty
   a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger read one");

   property p_finish;
      @(posedge clk) disable iff (reset || core_reset)
      $rose(temp_conv_active) |-> ##[1:1000] !temp_conv_active;
   endproperty
   a_finish: assert property (p_finish) else $error("conversion never ends");

   property p_rx_inhibit;
      @(posedge clk) disable iff (reset || core_reset)
      rx_inhibit == temp_conv_active;
   endproperty
   a_rx_inhibit: assert property (p_rx_inhibit) else $error("rx inhibit mismatch");

   property p_hold;
      @(posedge clk) disable iff (reset || core_reset)
      (st_q == tmr_pkg::TMR_CONV) |=> $stable(result_q);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved mid conversion");

   property p_result;
      @(posedge clk) disable iff (reset || core_reset)
      (st_q == tmr_pkg::TMR_DONE) |=> result_q == $past(sensor_code) && !temp_conv_active;
   endproperty
   a_result: assert property (p_result) else $error("result not captured");

   property p_lna_write;
      @(posedge clk) disable iff (reset || core_reset)
      hit(req, `TMR_ADDR_LNA) |=> tune.lna == $past(req.wdata);
   endproperty
   a_lna_write: assert property (p_lna_write) else $error("lna write lost");

   property p_afc;
      @(posedge clk) disable iff (reset || core_reset)
      !afc_apply |-> afc_offset_steps == 16'h0000;
   endproperty
   a_afc: assert property (p_afc) else $error("afc offset while disabled");

   property p_ready;
      @(posedge clk) disable iff (reset)
      core_reset |=> !ready;
   endproperty
   a_ready: assert property (p_ready) else $error("ready during reset");

   c_conv: cover property (@(posedge clk) $fell(temp_conv_active));
   c_lna_high: cover property (@(posedge clk) tune.lna == `TMR_LNA_HIGH);
   c_afc: cover property (@(posedge clk) afc_apply && tune.afc != 8'h00);
endmodule
`default_nettype wire

// ===== tb/tmr_host_model.sv
// host model: register strobes and reset pin
`timescale 1ns/1ps
`default_nettype none
module tmr_host_model
(
   input  wire logic            clk,
   input  wire logic            ready,
   output tmr_pkg::tmr_req_type req,
   output logic                 reset_pin
);
   initial
   begin
      req = '0;
      reset_pin = 1'b0;
   end
   // one strobe cycle; idle address and data are inverted so stale values never help
   task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
      // no strobe until the device shows it has left reset or 100 cycles have passed
      for (int i = 0; i < 100 && ready !== 1'b1; i++)
         @(posedge clk);
      @(posedge clk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic pulse_pin(input int n);
      @(posedge clk);
      reset_pin <= 1'b1;
      repeat (n) @(posedge clk);
      reset_pin <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== tb/temp_measure_test_regs_reset_test.sv
// self-checking bench for the temperature and test register block
`timescale 1ns/1ps
`default_nettype none
module temp_measure_test_regs_reset_test;
   localparam int CONV = 16;
   logic                  clk, reset, afc_en, pin, active, rx_inh, ready, afc_apply;
   logic [7:0]            sensor, rdata, v;
   logic [15:0]           afc_steps;
   tmr_pkg::tmr_req_type  req;
   tmr_pkg::tmr_tune_type tune;
   int                    fail_count = 0, checks_done = 0, seed = 55795, n, k;
   logic [6:0]            addr_tab [5] = '{7'h58, 7'h5a, 7'h5c, 7'h6f, 7'h71};
   logic [7:0]            rst_tab [5] = '{8'h1b, 8'h55, 8'h70, 8'h30, 8'h00};
   logic [7:0]            val_tab [10] = '{8'h2d, 8'h5d, 8'h7c, 8'h00, 8'h5a,
                                           8'h1b, 8'h55, 8'h70, 8'h30, 8'ha5};
   logic [7:0]            mdl [5];
   tmr_host_model host (.clk(clk), .ready(ready), .req(req), .reset_pin(pin));
   tmr_top #(.CONV_CYCLES(CONV), .HOLD_CYCLES(16)) DUT
   (
      .clk(clk), .reset(reset), .reset_pin(pin), .req(req), .sensor_code(sensor),
      .low_index_afc_enable(afc_en), .rdata(rdata), .temp_conv_active(active),
      .rx_inhibit(rx_inh), .ready(ready), .afc_apply(afc_apply),
      .afc_offset_steps(afc_steps), .tune(tune)
   );
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      host.access(1'b0, a, 8'h00);
      @(posedge clk);
      #1 check({32'h0, rdata}, {32'h0, exp});
   endtask
   // waits for ready to reach lvl, gives up after a bounded count
   task automatic wait_ready(input logic lvl);
      n = 0;
      while (ready !== lvl && n < 100)
      begin
         @(posedge clk);
         #1 n++;
      end
      check({39'h0, ready}, {39'h0, lvl});
      if (n == 100)
         give_verdict;
   endtask
   // host only writes the documented settings; afc enable is low while these are set
   function automatic logic [7:0] legal_val(input int r, input logic [7:0] x);
      case (r)
         0: legal_val = x[0] ? 8'h2d : 8'h1b;
         1: legal_val = x[0] ? 8'h5d : 8'h55;
         2: legal_val = x[0] ? 8'h7c : 8'h70;
         3: legal_val = x[0] ? 8'h30 : 8'h00;
         default: legal_val = x;
      endcase
   endfunction
   function automatic logic [39:0] tune_exp();
      return {mdl[0], mdl[1], mdl[2], mdl[3], mdl[4]};
   endfunction
   initial
   begin
      reset = 1'b1;
      sensor = 8'h00;
      afc_en = 1'b0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      wait_ready(1'b1);
      for (int i = 0; i < 5; i++)
      begin
         mdl[i] = rst_tab[i];
         rd_chk(addr_tab[i], rst_tab[i]);
      end
      check(tune, tune_exp());
      rd_chk(7'h4e, 8'h01);
      rd_chk(7'h4f, 8'h00);
      rd_chk(7'h60, 8'h00);
      for (int i = 0; i < 15; i++)
      begin
         k = i % 5;
         v = (i < 10) ? val_tab[i] : legal_val(k, 8'($random(seed)));
         host.access(1'b1, addr_tab[k], v);
         mdl[k] = v;
         rd_chk(addr_tab[k], mdl[k]);
      end
      check(tune, tune_exp());
      @(posedge clk);
      sensor <= 8'($random(seed));
      host.access(1'b1, 7'h4e, 8'h08);
      #1 check({38'h0, active, rx_inh}, 40'h3);
      rd_chk(7'h4e, 8'h05);
      rd_chk(7'h4f, 8'h00);
      n = 0;
      while (active !== 1'b0 && n < 100)
      begin
         @(posedge clk);
         #1 n++;
      end
      check({39'h0, rx_inh}, 40'h0);
      if (n == 100)
         give_verdict;
      rd_chk(7'h4f, sensor);
      rd_chk(7'h4e, 8'h01);
      host.access(1'b1, 7'h4e, 8'h08);
      n = 0;
      #1;
      while (active === 1'b1 && n < 100)
      begin
         @(posedge clk);
         #1 n++;
      end
      check(40'(n), 40'(CONV + 1));
      if (n == 100)
         give_verdict;
      @(posedge clk);
      afc_en <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check({afc_apply, afc_steps}, {1'b1, 8'h00, mdl[4]});
      @(posedge clk);
      afc_en <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check({afc_apply, afc_steps}, 17'h0);
      host.pulse_pin(4000);
      wait_ready(1'b0);
      for (int i = 0; i < 5; i++)
         mdl[i] = rst_tab[i];
      check(tune, tune_exp());
      wait_ready(1'b1);
      rd_chk(7'h4f, 8'h00);
      give_verdict;
   end
endmodule
`default_nettype wire
